// File: design/usf_status_flow.sv
`timescale 1ns/1ps
`default_nettype none
`include "usf_consts.svh"

module usf_status_flow (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// Host register port
	input  wire logic [2:0]            reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [7:0]            reg_wdata,
	output logic [7:0]                 reg_rdata,
	// Settings held elsewhere in the UART
	input  wire logic [7:0]            enhanced_feature_reg,
	input  wire logic [7:0]            interrupt_enable_reg,
	input  wire logic [7:0]            fifo_control_reg,
	input  wire logic [7:0]            xon_char,
	input  wire logic [7:0]            xoff_char,
	// Receiver side
	input  wire usf_pkg::usf_rx_char_t rx_char,
	input  wire logic                  rx_char_valid,
	input  wire logic                  rx_pop,
	output usf_pkg::usf_rx_char_t      rx_head,
	output logic [6:0]                 rx_count,
	output logic                       rx_trig_hit,
	// Transmitter side
	input  wire logic [6:0]            tx_level,
	input  wire logic                  tx_shift_busy,
	input  wire logic                  tx_serial,
	output logic                       tx_trig_hit,
	output logic                       tx_halt,
	output logic                       send_xon,
	output logic                       send_xoff,
	output logic                       presc_tick,
	output logic                       ir_enable,
	// Serial and modem pins
	input  wire logic                  rx_pin,
	input  wire usf_pkg::usf_modem_in_t modem_pins,
	output logic                       rx_line,
	output logic                       tx_pin,
	output logic                       rts_n_pin,
	output logic                       dtr_n_pin,
	output logic                       msr_irq
);
	import usf_pkg::*;

	usf_state_t st_ff;
	usf_state_t nxt_st;

	function automatic logic [6:0] lvl4(input logic [3:0] nib);
		lvl4 = {1'b0, nib, 2'b00};
	endfunction

	// Any receive error tag on a character
	function automatic logic has_err(input usf_rx_char_t c);
		has_err = c.par | c.frm | c.brk;
	endfunction

	// Software flow control active for any nonzero selection
	function automatic logic sw_flow(input logic [7:0] feat);
		sw_flow = feat[3:0] != 4'h0;
	endfunction

	// Fifo-control receive trigger choice
	function automatic logic [6:0] rx_choice(input logic [1:0] sel);
		unique case (sel)
			2'b00: rx_choice = `USF_RXT_0;
			2'b01: rx_choice = `USF_RXT_1;
			2'b10: rx_choice = `USF_RXT_2;
			2'b11: rx_choice = `USF_RXT_3;
		endcase
	endfunction

	// Fifo-control transmit trigger choice
	function automatic logic [6:0] tx_choice(input logic [1:0] sel);
		unique case (sel)
			2'b00: tx_choice = `USF_TXT_0;
			2'b01: tx_choice = `USF_TXT_1;
			2'b10: tx_choice = `USF_TXT_2;
			2'b11: tx_choice = `USF_TXT_3;
		endcase
	endfunction

	logic          loop;
	logic [3:0]    msr_now;
	logic [7:0]    line_status;
	logic [7:0]    modem_status;
	logic          alt_map;
	logic          push;
	logic          pop;
	logic          ctrl_char;
	logic [6:0]    rx_trig;
	logic [6:0]    tx_trig;
	usf_rx_char_t  head;

	// Decoded strobes, levels and views
	logic          flow_on;
	logic          head_ok;
	logic          head_err;
	logic          ovr_set;
	logic          rd_lsr;
	logic          rd_msr;
	logic          tx_empty;
	logic [6:0]    tx_space;
	logic [6:0]    halt_lvl;
	logic [6:0]    resume_lvl;
	logic [3:0]    msr_chg;

	assign loop    = st_ff.modem_control[`USF_MCR_LOOP];
	assign alt_map = enhanced_feature_reg[`USF_EFR_ENH] & st_ff.modem_control[`USF_MCR_AUX1];
	assign head    = st_ff.mem[st_ff.rd_ptr];

	assign flow_on    = sw_flow(enhanced_feature_reg);
	assign head_ok    = st_ff.cnt != 7'h00;
	assign head_err   = has_err(head);
	assign rd_lsr     = reg_rd && reg_addr == `USF_OFS_LSR;
	assign rd_msr     = reg_rd && reg_addr == `USF_OFS_MSR_TCR && !alt_map;
	assign tx_empty   = tx_level == 7'h00;
	assign tx_space   = `USF_FIFO_DEPTH - tx_level;
	assign halt_lvl   = lvl4(st_ff.halt_resume_levels[3:0]);
	assign resume_lvl = lvl4(st_ff.halt_resume_levels[7:4]);

	// Status bits in order cts, dsr, ri, cd
	always_comb begin
		if (loop) begin
			msr_now = {st_ff.modem_control[`USF_MCR_RTS], st_ff.modem_control[`USF_MCR_DTR],
				st_ff.modem_control[`USF_MCR_AUX1], st_ff.modem_control[`USF_MCR_AUX2]};
		end else begin
			msr_now = ~{modem_pins.cts_n, modem_pins.dsr_n,
				modem_pins.ri_n, modem_pins.cd_n};
		end
	end

	// Change flags in status order: cts, dsr, ring end, cd
	always_comb begin
		msr_chg[0] = msr_now[3] ^ st_ff.msr_prev[3];
		msr_chg[1] = msr_now[2] ^ st_ff.msr_prev[2];
		msr_chg[2] = st_ff.msr_prev[1] & ~msr_now[1];
		msr_chg[3] = msr_now[0] ^ st_ff.msr_prev[0];
	end

	assign modem_status = {msr_now[0], msr_now[1], msr_now[2], msr_now[3], st_ff.delta};

	// Line status; error tags describe the head character
	always_comb begin
		line_status[7] = st_ff.err_cnt != 7'h00;
		line_status[6] = tx_empty & ~tx_shift_busy;
		line_status[5] = tx_empty;
		line_status[4] = head_ok & head.brk;
		line_status[3] = head_ok & head.frm;
		line_status[2] = head_ok & head.par;
		line_status[1] = st_ff.overrun;
		line_status[0] = head_ok;
	end

	assign ctrl_char = flow_on &&
		(rx_char.data == xon_char || rx_char.data == xoff_char);

	// Trigger selection
	always_comb begin
		if (st_ff.fifo_trigger_levels[7:4] != 4'h0) begin
			rx_trig = lvl4(st_ff.fifo_trigger_levels[7:4]);
		end else begin
			rx_trig = rx_choice(fifo_control_reg[7:6]);
		end
		if (st_ff.fifo_trigger_levels[3:0] != 4'h0) begin
			tx_trig = lvl4(st_ff.fifo_trigger_levels[3:0]);
		end else begin
			tx_trig = tx_choice(fifo_control_reg[5:4]);
		end
	end

	always_comb begin
		nxt_st = st_ff;
		push = 1'b0;
		pop = rx_pop && st_ff.cnt != 7'h00;
		nxt_st.send_xon = 1'b0;
		nxt_st.send_xoff = 1'b0;
		ovr_set = 1'b0;

		// Clock prescaler, held at zero while dividing by one
		if (st_ff.modem_control[`USF_MCR_PRESC]) begin
			nxt_st.presc_cnt = st_ff.presc_cnt + 2'h1;
		end else begin
			nxt_st.presc_cnt = 2'h0;
		end
		nxt_st.presc_tick = ~st_ff.modem_control[`USF_MCR_PRESC] ||
			st_ff.presc_cnt == `USF_PRESC_LAST;

		// Break latch released once the line returns high
		if (rx_line) begin
			nxt_st.brk_seen = 1'b0;
		end

		// Incoming characters
		if (rx_char_valid) begin
			if (st_ff.modem_control[`USF_MCR_XANY]) begin
				nxt_st.sw_halt = 1'b0;
			end
			if (ctrl_char) begin
				nxt_st.sw_halt = rx_char.data == xoff_char;
			end else if (rx_char.brk && st_ff.brk_seen) begin
				nxt_st.brk_seen = 1'b1;
			end else if (st_ff.cnt == `USF_FIFO_DEPTH && !pop) begin
				nxt_st.overrun = 1'b1;
				ovr_set = 1'b1;
			end else begin
				push = 1'b1;
				nxt_st.brk_seen = rx_char.brk;
			end
		end

		if (push) begin
			nxt_st.mem[st_ff.wr_ptr] = rx_char;
			nxt_st.wr_ptr = st_ff.wr_ptr + 6'h01;
		end
		if (pop) begin
			nxt_st.rd_ptr = st_ff.rd_ptr + 6'h01;
		end
		nxt_st.cnt = st_ff.cnt + {6'h00, push} - {6'h00, pop};
		nxt_st.err_cnt = st_ff.err_cnt
			+ {6'h00, push & has_err(rx_char)}
			- {6'h00, pop & head_err};

		// Halt and resume thresholds
		// A zero halt level holds the sender off for good
		if (!st_ff.rts_halt && nxt_st.cnt >= halt_lvl) begin
			nxt_st.rts_halt = 1'b1;
			nxt_st.send_xoff = flow_on;
		end else if (st_ff.rts_halt && nxt_st.cnt <= resume_lvl && nxt_st.cnt < halt_lvl) begin
			nxt_st.rts_halt = 1'b0;
			nxt_st.send_xon = flow_on;
		end

		// Modem change flags; a new change wins over the read clear
		nxt_st.msr_prev = msr_now;
		if (rd_msr) begin
			nxt_st.delta = 4'h0;
		end
		nxt_st.delta = nxt_st.delta | msr_chg;

		// Register reads
		if (reg_rd) begin
			unique case (reg_addr)
				`USF_OFS_MCR:     nxt_st.rdata = st_ff.modem_control;
				`USF_OFS_LSR:     nxt_st.rdata = line_status;
				`USF_OFS_MSR_TCR: nxt_st.rdata = alt_map ? st_ff.halt_resume_levels : modem_status;
				`USF_OFS_SPR_TLR: nxt_st.rdata = alt_map ? st_ff.fifo_trigger_levels : st_ff.scratch;
				default:          nxt_st.rdata = 8'h00;
			endcase
			if (rd_lsr) begin
				nxt_st.overrun = ovr_set;
			end
		end

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				`USF_OFS_MCR: begin
					if (enhanced_feature_reg[`USF_EFR_ENH]) begin
						nxt_st.modem_control = reg_wdata;
					end else begin
						nxt_st.modem_control = (st_ff.modem_control & ~`USF_MCR_OPEN_MSK) |
							(reg_wdata & `USF_MCR_OPEN_MSK);
					end
				end
				`USF_OFS_MSR_TCR: begin
					if (alt_map) begin
						nxt_st.halt_resume_levels = reg_wdata;
					end
				end
				`USF_OFS_SPR_TLR: begin
					if (alt_map) begin
						nxt_st.fifo_trigger_levels = reg_wdata;
					end else begin
						nxt_st.scratch = reg_wdata;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.modem_control <= `USF_MCR_RST;
			st_ff.scratch <= `USF_SPR_RST;
			st_ff.halt_resume_levels <= `USF_TCR_RST;
			st_ff.fifo_trigger_levels <= `USF_TLR_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign reg_rdata   = st_ff.rdata;
	assign rx_head     = head;
	assign rx_count    = st_ff.cnt;
	assign rx_trig_hit = st_ff.cnt >= rx_trig;
	assign tx_trig_hit = tx_space >= tx_trig;
	assign tx_halt     = st_ff.sw_halt |
		(enhanced_feature_reg[`USF_EFR_ACTS] & ~msr_now[3]);
	assign send_xon    = st_ff.send_xon;
	assign send_xoff   = st_ff.send_xoff;
	assign presc_tick  = st_ff.presc_tick;
	assign ir_enable   = st_ff.modem_control[`USF_MCR_IR];
	assign rx_line     = loop ? tx_serial : rx_pin;
	assign tx_pin      = loop | tx_serial;
	assign rts_n_pin   = loop | ~(st_ff.modem_control[`USF_MCR_RTS] &
		~(enhanced_feature_reg[`USF_EFR_ARTS] & st_ff.rts_halt));
	assign dtr_n_pin   = loop | ~st_ff.modem_control[`USF_MCR_DTR];
	assign msr_irq     = interrupt_enable_reg[`USF_IER_MSI] & (st_ff.delta != 4'h0);

endmodule

`default_nettype wire

// File: include/usf_consts.svh
`ifndef USF_CONSTS_SVH
`define USF_CONSTS_SVH

// Register offsets on the host register port
`define USF_OFS_MCR      3'h4
`define USF_OFS_LSR      3'h5
`define USF_OFS_MSR_TCR  3'h6
`define USF_OFS_SPR_TLR  3'h7

// Modem control bit positions
`define USF_MCR_DTR      0
`define USF_MCR_RTS      1
`define USF_MCR_AUX1     2
`define USF_MCR_AUX2     3
`define USF_MCR_LOOP     4
`define USF_MCR_XANY     5
`define USF_MCR_IR       6
`define USF_MCR_PRESC    7
`define USF_MCR_OPEN_MSK 8'h1f

// Enhanced feature and interrupt enable bits
`define USF_EFR_ENH      4
`define USF_EFR_ARTS     6
`define USF_EFR_ACTS     7
`define USF_IER_MSI      3

// Reset values
`define USF_MCR_RST      8'h00
`define USF_SPR_RST      8'hff
`define USF_TCR_RST      8'h00
`define USF_TLR_RST      8'h00

// FIFO depth and prescaler last count
`define USF_FIFO_DEPTH   7'h40
`define USF_PRESC_LAST   2'h3

// Trigger choices from the fifo control bits
`define USF_RXT_0        7'h08
`define USF_RXT_1        7'h10
`define USF_RXT_2        7'h38
`define USF_RXT_3        7'h3c
`define USF_TXT_0        7'h08
`define USF_TXT_1        7'h10
`define USF_TXT_2        7'h20
`define USF_TXT_3        7'h38

`endif

// File: include/usf_pkg.sv
package usf_pkg;

	typedef struct packed {
		logic [7:0] data;
		logic       par;
		logic       frm;
		logic       brk;
	} usf_rx_char_t;

	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic ri_n;
		logic cd_n;
	} usf_modem_in_t;

	typedef struct packed {
		usf_rx_char_t [63:0] mem;
		logic [5:0]          rd_ptr;
		logic [5:0]          wr_ptr;
		logic [6:0]          cnt;
		logic [6:0]          err_cnt;
		logic                overrun;
		logic                brk_seen;
		logic [7:0]          modem_control;
		logic [7:0]          scratch;
		logic [7:0]          halt_resume_levels;
		logic [7:0]          fifo_trigger_levels;
		logic [3:0]          delta;
		logic [3:0]          msr_prev;
		logic                sw_halt;
		logic                rts_halt;
		logic                send_xon;
		logic                send_xoff;
		logic [1:0]          presc_cnt;
		logic                presc_tick;
		logic [7:0]          rdata;
	} usf_state_t;

endpackage

// File: test/usf_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module usf_far_model (
	// Clock and requests from the bench
	input  wire logic             core_clk,
	input  wire logic [3:0]       want,
	input  wire logic [1:0]       lag,
	input  wire logic             brk,
	// Lines toward the block
	output usf_pkg::usf_modem_in_t modem_pins,
	output logic                  rx_pin
);
	import usf_pkg::*;
	logic [3:0] pend;
	int         n;
	initial begin
		modem_pins = 4'hf;
		pend = 4'hf;
		n = 0;
	end
	// Pins follow a new request after a varying delay
	always @(negedge core_clk) begin
		if (want != pend) begin
			pend <= want;
			n <= lag;
		end else if (n > 0)
			n <= n - 1;
		else
			modem_pins <= want;
	end
	// Line idles at mark, held low for a break
	assign rx_pin = !brk;
endmodule
`default_nettype wire

// File: test/usf_sf_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module usf_sf_asserts (
	// Clock, reset, host port
	input wire logic                   core_clk,
	input wire logic                   rst,
	input wire logic [2:0]             reg_addr,
	input wire logic                   reg_wr,
	input wire logic [7:0]             enhanced_feature_reg,
	input wire logic [7:0]             interrupt_enable_reg,
	// Receive side
	input wire logic                   rx_char_valid,
	input wire logic                   rx_pop,
	input wire usf_pkg::usf_rx_char_t  rx_head,
	input wire logic [6:0]             rx_count,
	// Flow and pins
	input wire logic                   send_xon,
	input wire logic                   send_xoff,
	input wire logic                   presc_tick,
	input wire logic                   ir_enable,
	input wire usf_pkg::usf_modem_in_t modem_pins,
	input wire logic                   rx_pin,
	input wire logic                   rx_line,
	input wire logic                   tx_pin,
	input wire logic                   tx_halt,
	input wire logic                   msr_irq
);
	import usf_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_loop_route: assert property (!tx_pin |-> rx_line == rx_pin)
		else $error("receiver not fed from pin");
	chk_ir_gate: assert property (reg_wr && reg_addr == 3'h4 && !enhanced_feature_reg[4] |=> $stable(ir_enable))
		else $error("gated bit changed");
	chk_presc_div: assert property ($fell(presc_tick) |-> ##3 presc_tick)
		else $error("prescaler not one in four");
	chk_full_keep: assert property (rx_count == 7'h40 && rx_char_valid && !rx_pop
		|=> rx_count == 7'h40 && $stable(rx_head)) else $error("full fifo disturbed");
	chk_irq_cause: assert property (msr_irq |-> interrupt_enable_reg[3])
		else $error("modem irq while disabled");
	chk_cts_halt: assert property (enhanced_feature_reg[7] && modem_pins.cts_n && !tx_pin |-> ##[0:2] tx_halt)
		else $error("no halt on cts");
	chk_xoff_pulse: assert property (send_xoff |=> !send_xoff)
		else $error("xoff request too long");
	chk_xon_pulse: assert property (send_xon |=> !send_xon && !send_xoff)
		else $error("xon request too long");
	cover property (rx_count == 7'h40 && rx_char_valid);
	cover property (send_xoff);
	cover property (msr_irq);
endmodule
bind usf_status_flow usf_sf_asserts chk_u (.core_clk, .rst, .reg_addr, .reg_wr, .enhanced_feature_reg, .interrupt_enable_reg,
	.rx_char_valid, .rx_pop, .rx_head, .rx_count, .send_xon, .send_xoff, .presc_tick,
	.ir_enable, .modem_pins, .rx_pin, .rx_line, .tx_pin, .tx_halt, .msr_irq);
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import usf_pkg::*;
	logic          core_clk, rst, reg_wr, reg_rd, rx_char_valid, rx_pop, tx_shift_busy, tx_serial;
	logic          brk, rd_d, rx_trig_hit, tx_trig_hit, tx_halt, send_xon, send_xoff, presc_tick;
	logic          ir_enable, rx_pin, rx_line, tx_pin, rts_n_pin, dtr_n_pin, msr_irq;
	logic [2:0]    reg_addr;
	logic [3:0]    want;
	logic [6:0]    rx_count, tx_level;
	logic [7:0]    reg_wdata, reg_rdata, enhanced_feature_reg, interrupt_enable_reg, fifo_control_reg, r;
	logic [15:0]   e;
	logic [15:0]   q[$];
	usf_rx_char_t  rx_char, rx_head;
	usf_modem_in_t modem_pins;
	int            n_fail, tests_run, n_xoff, n_xon, k;
	usf_status_flow dut_u (.core_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.enhanced_feature_reg, .interrupt_enable_reg, .fifo_control_reg, .xon_char(8'h11), .xoff_char(8'h13), .rx_char, .rx_char_valid,
		.rx_pop, .rx_head, .rx_count, .rx_trig_hit, .tx_level, .tx_shift_busy, .tx_serial,
		.tx_trig_hit, .tx_halt, .send_xon, .send_xoff, .presc_tick, .ir_enable, .rx_pin,
		.modem_pins, .rx_line, .tx_pin, .rts_n_pin, .dtr_n_pin, .msr_irq);
	usf_far_model far_u (.core_clk, .want, .lag(r[1:0]), .brk, .modem_pins, .rx_pin);
	always #2.5 core_clk = !core_clk;
	function automatic logic [7:0] lf(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] x);
		tests_run++;
		if (s !== x) begin
			n_fail++;
			$display("wrong value at %0t: saw %h want %h", $time, s, x);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	// Expected value and mask go on the queue
	task automatic rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] m);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		q.push_back({m, x});
		@(negedge core_clk);
		reg_rd = 1'b0;
	endtask
	// Back-to-back pushes or pops
	task automatic xfer(input int n, input logic p, input logic [2:0] t, input logic [7:0] d);
		repeat (n) begin
			@(negedge core_clk);
			rx_char = {(d != 8'h00) ? d : (r | 8'h80), t};
			r = lf(r);
			rx_char_valid = !p;
			rx_pop = p;
		end
		@(negedge core_clk);
		rx_char_valid = 1'b0;
		rx_pop = 1'b0;
	endtask
	task automatic trig(input logic [6:0] lvl, input logic x);
		tx_level = lvl;
		idle(2);
		chk({7'h0, tx_trig_hit}, {7'h0, x});
	endtask
	task automatic reset;
		rst = 1'b1;
		idle(3);
		rst = 1'b0;
	endtask
	always @(posedge core_clk) rd_d <= reg_rd;
	always @(negedge core_clk) begin
		if (rd_d === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			chk(reg_rdata & e[15:8], e[7:0]);
		end
		if (send_xoff === 1'b1)
			n_xoff++;
		if (send_xon === 1'b1)
			n_xon++;
	end
	initial begin
		#50000;
		n_fail++;
		end_of_test;
	end
	initial begin
		{reg_wr, reg_rd, rx_char_valid, rx_pop, tx_shift_busy, tx_serial, brk} = '0;
		{reg_addr, reg_wdata, enhanced_feature_reg, interrupt_enable_reg, fifo_control_reg, tx_level, rx_char} = '0;
		{n_fail, tests_run, n_xoff, n_xon} = '0;
		core_clk = 1'b0;
		want = 4'hf;
		r = 8'h62;
		reset;
		rd(3'h7, 8'hff, 8'hff);
		wr(3'h7, 8'h5a);
		rd(3'h7, 8'h5a, 8'hff);
		wr(3'h4, 8'hff);
		rd(3'h4, 8'h1f, 8'hff);
		enhanced_feature_reg = 8'h10;
		wr(3'h4, 8'he0);
		rd(3'h4, 8'he0, 8'hff);
		chk({7'h0, ir_enable}, 8'h01);
		k = 0;
		repeat (8) begin
			@(negedge core_clk);
			k += presc_tick;
		end
		chk(8'(k), 8'h02);
		wr(3'h4, 8'h00);
		rd(3'h6, 8'h0f, 8'hff);
		interrupt_enable_reg = 8'h08;
		want = 4'b0111;
		idle(8);
		chk({7'h0, msr_irq}, 8'h01);
		rd(3'h6, 8'h11, 8'hff);
		rd(3'h6, 8'h10, 8'hff);
		chk({7'h0, msr_irq}, 8'h00);
		want = 4'b0101;
		idle(8);
		rd(3'h6, 8'h50, 8'hff);
		want = 4'b0111;
		idle(8);
		rd(3'h6, 8'h14, 8'hff);
		enhanced_feature_reg = 8'h00;
		wr(3'h4, 8'h1b);
		rd(3'h6, 8'hb0, 8'hf0);
		chk({4'h0, tx_pin, rts_n_pin, dtr_n_pin, rx_line}, 8'h0e);
		wr(3'h4, 8'h00);
		rd(3'h6, 8'h1a, 8'hff);
		rd(3'h6, 8'h10, 8'hff);
		rd(3'h5, 8'h60, 8'hff);
		tx_level = 7'h01;
		rd(3'h5, 8'h00, 8'hff);
		tx_level = 7'h00;
		tx_shift_busy = 1'b1;
		rd(3'h5, 8'h20, 8'hff);
		tx_shift_busy = 1'b0;
		xfer(1, 1'b0, 3'b100, 8'h00);
		rd(3'h5, 8'he5, 8'hff);
		xfer(1, 1'b0, 3'b010, 8'h00);
		xfer(1, 1'b1, 3'b000, 8'h00);
		rd(3'h5, 8'he9, 8'hff);
		xfer(1, 1'b1, 3'b000, 8'h00);
		rd(3'h5, 8'h60, 8'hff);
		brk = 1'b1;
		xfer(2, 1'b0, 3'b001, 8'h00);
		chk({1'b0, rx_count}, 8'h01);
		rd(3'h5, 8'hf1, 8'hff);
		brk = 1'b0;
		xfer(1, 1'b1, 3'b000, 8'h00);
		enhanced_feature_reg = 8'h5a;
		wr(3'h4, 8'h06);
		wr(3'h6, 8'h12);
		rd(3'h6, 8'h12, 8'hff);
		{n_xoff, n_xon} = '0;
		xfer(8, 1'b0, 3'b000, 8'h00);
		idle(3);
		chk({7'h0, rts_n_pin}, 8'h01);
		chk(8'(n_xoff), 8'h01);
		xfer(57, 1'b0, 3'b000, 8'h00);
		chk({1'b0, rx_count}, 8'h40);
		rd(3'h5, 8'h63, 8'hff);
		rd(3'h5, 8'h61, 8'hff);
		xfer(60, 1'b1, 3'b000, 8'h00);
		idle(3);
		chk(8'(n_xon), 8'h01);
		chk({7'h0, rts_n_pin}, 8'h00);
		wr(3'h7, 8'h32);
		trig(7'h38, 1'b1);
		trig(7'h39, 1'b0);
		xfer(7, 1'b0, 3'b000, 8'h00);
		chk({7'h0, rx_trig_hit}, 8'h00);
		xfer(1, 1'b0, 3'b000, 8'h00);
		chk({7'h0, rx_trig_hit}, 8'h01);
		wr(3'h7, 8'h00);
		fifo_control_reg = 8'h50;
		trig(7'h30, 1'b1);
		trig(7'h31, 1'b0);
		chk({7'h0, rx_trig_hit}, 8'h00);
		wr(3'h4, 8'h22);
		rd(3'h7, 8'h5a, 8'hff);
		xfer(1, 1'b0, 3'b000, 8'h13);
		chk({tx_halt, rx_count}, 8'h8c);
		xfer(1, 1'b0, 3'b000, 8'h41);
		chk({tx_halt, rx_count}, 8'h0d);
		enhanced_feature_reg = 8'h90;
		want = 4'b1111;
		idle(8);
		chk({7'h0, tx_halt}, 8'h01);
		want = 4'b0111;
		idle(8);
		chk({7'h0, tx_halt}, 8'h00);
		reset;
		rd(3'h7, 8'hff, 8'hff);
		idle(2);
		end_of_test;
	end
endmodule
`default_nettype wire
